// [rtl/bci_pkg.sv]
// shared constants, states and carriers for the bus controller host/dma port
`default_nettype none
package bci_pkg;
    localparam int ADDR_W       = 16;  // up to 64k words of shared memory
    localparam int DATA_W       = 16;
    localparam int REG_IDX_W    = 4;   // sixteen internal registers
    localparam int CMD_W        = 16;
    localparam int CMD_TA_LSB   = 11;  // terminal address field starts at this bit
    localparam int LGL_W        = CMD_TA_LSB;
    localparam logic PIN_OFF    = 1'b1;  // idle level of every active-low pin
    localparam logic OE_OFF     = 1'b1;  // output enable released
    localparam logic [ADDR_W-1:0] HIST_BASE_DEF = 16'h0100;
    localparam logic [ADDR_W-1:0] ADDR_ONE      = 16'h0001;

    // one memory access presented by the protocol core
    typedef struct packed {
        logic              write;
        logic              last;   // final word of this transfer
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bci_acc_t;

    // host and arbiter pins that are synchronised together
    typedef struct packed {
        logic                 cs_n;
        logic                 rd_n;
        logic                 wr_n;
        logic                 msel_n;
        logic                 grant_n;
        logic                 aen_n;
        logic                 legal;
        logic [REG_IDX_W-1:0] idx;
    } bci_pins_t;

    localparam bci_pins_t PINS_RST = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, msel_n: 1'b1,
                                       grant_n: 1'b1, aen_n: 1'b1, legal: 1'b0,
                                       idx: 4'h0};

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_WAIT  = 6'h02,
        ST_OWN   = 6'h04,
        ST_SETUP = 6'h08,
        ST_STRB  = 6'h10,
        ST_DONE  = 6'h20
    } bci_state_t;
endpackage
`default_nettype wire

// [rtl/bci_sync.sv]
// two-flop synchroniser for a vector of pin levels
`default_nettype none
module bci_sync #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_arst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_r <= RST;
            o_q    <= RST;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule // bci_sync
`default_nettype wire

// [rtl/bci_port.sv]
// host, dma and legalization port of the bus controller / remote terminal
// Operation
// - dma transfer for bc blocks or rt commands
// - request, then start only after grant
// - ack while owning buses; ends on ack release
// - drive indicator only while driving buses
// - address driven only while address gate allows
// - grant passes to chain when not requesting
// - pseudo-dual-port forwards host memory strobes
// - host memory strobes ignored during own access
// - standard mode strobes only after grant
// - buses floating except register read or drive
// - register access ignored during own access
// - rt busy blocks starting dma transfers
// - burst indicator on multiple consecutive accesses
// - four address bits select sixteen registers
// - shared memory space up to 64k words
// - descriptor method decides command legality
// - command without terminal address on legal bus
// - legal input high legal, low illegal
// - legal bus floats during master reset
// - per-channel transmitter-on and active channel outputs
// - interrupt events logged in memory history list
`default_nettype none
module bci_port import bci_pkg::*; #(
    parameter logic [ADDR_W-1:0] HIST_BASE = HIST_BASE_DEF
) (
    // clock and master reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_arst_n,
    // configuration levels
    input  wire logic              i_rt_mode,
    input  wire logic              i_rt_busy,
    input  wire logic              i_pdp_mode,
    input  wire logic              i_bus_lgl_mode,
    // protocol core memory access
    input  wire logic              i_acc_valid,
    input  wire bci_acc_t          i_acc,
    output logic                   o_acc_done,
    output logic      [DATA_W-1:0] o_acc_rdata,
    // interrupt event logging
    input  wire logic              i_evt_valid,
    input  wire logic [DATA_W-1:0] i_evt_word,
    output logic      [ADDR_W-1:0] o_hist_ptr,
    // internal register file
    output logic                   o_reg_rd,
    output logic                   o_reg_wr,
    output logic   [REG_IDX_W-1:0] o_reg_idx,
    output logic      [DATA_W-1:0] o_reg_wdata,
    input  wire logic [DATA_W-1:0] i_reg_rdata,
    // host and arbiter pins
    input  wire logic              i_cs_n,
    input  wire logic              i_rd_n,
    input  wire logic              i_wr_n,
    input  wire logic              i_host_memory_select_in_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_bus_grant_in_n,
    input  wire logic              i_address_output_gate_n,
    output logic                   o_bus_request_out_n,
    output logic                   o_bus_owned_ack_n,
    output logic                   o_grant_chain_out_n,
    output logic                   o_bus_drive_indicator_n,
    output logic                   o_burst_n,
    // memory strobes
    output logic                   o_memory_read_out_n,
    output logic                   o_memory_store_out_n,
    output logic                   o_memory_select_out_n,
    // address and data buses
    output logic      [ADDR_W-1:0] o_addr,
    output logic                   o_addr_oe_n,
    input  wire logic [DATA_W-1:0] i_data,
    output logic      [DATA_W-1:0] o_data,
    output logic                   o_data_oe_n,
    // command legalization
    input  wire logic [CMD_W-1:0]  i_cmd_word,
    input  wire logic              i_cmd_valid,
    input  wire logic              i_desc_legal,
    input  wire logic              i_command_legal_in,
    output logic      [LGL_W-1:0]  o_lgl_bus,
    output logic                   o_lgl_oe_n,
    output logic                   o_cmd_legal,
    // transceiver support
    input  wire logic              i_tx_on_a,
    input  wire logic              i_tx_on_b,
    input  wire logic              i_chan_a_active,
    output logic                   o_failsafe_timer_on_ch_a_n,
    output logic                   o_failsafe_timer_on_ch_b_n,
    output logic                   o_active_channel_indicator
);
    bci_pins_t  pin_raw;
    bci_pins_t  pin_s;
    bci_state_t st_r;
    bci_acc_t   cur_r;
    logic       src_hist_r;
    logic       hist_pend_r;
    logic [DATA_W-1:0] hist_word_r;
    logic       rd_prev_r;
    logic       wr_prev_r;
    logic       want;
    logic       blocked;
    logic       host_rd;
    logic [DATA_W-1:0] data_s;

    // host, arbiter and legal pins go through two flops first
    assign pin_raw = '{cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n,
                       msel_n: i_host_memory_select_in_n, grant_n: i_bus_grant_in_n,
                       aen_n: i_address_output_gate_n, legal: i_command_legal_in,
                       idx: i_addr[REG_IDX_W-1:0]};

    bci_sync #(.W($bits(bci_pins_t)), .RST(PINS_RST)) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_d       (pin_raw),
        .o_q       (pin_s)
    );

    // host write data arrives with the strobes, so it takes the same two flops
    bci_sync #(.W(DATA_W)) u_data_sync (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_d       (i_data),
        .o_q       (data_s)
    );

    // request sources: core transfers first, history words when core is quiet
    assign want    = i_acc_valid || hist_pend_r;
    assign blocked = i_rt_mode && i_rt_busy;
    assign host_rd = !pin_s.cs_n && !pin_s.rd_n;

    // transfer sequencer
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r <= ST_IDLE;
        end else begin
            case (st_r)
                ST_IDLE:  if (want && !blocked) st_r <= ST_WAIT;
                ST_WAIT:  if (!pin_s.grant_n) st_r <= ST_OWN;
                ST_OWN:   if (!pin_s.aen_n && want) st_r <= ST_SETUP;
                ST_SETUP: st_r <= ST_STRB;
                ST_STRB:  st_r <= ST_DONE;
                ST_DONE:  st_r <= cur_r.last ? ST_IDLE : ST_OWN;
                default:  st_r <= ST_IDLE;
            endcase
        end
    end

    // latch the access word on entry to the drive phase
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cur_r      <= '0;
            src_hist_r <= 1'b0;
        end else if (st_r == ST_OWN && !pin_s.aen_n && want) begin
            src_hist_r <= !i_acc_valid;
            if (i_acc_valid) begin
                cur_r <= i_acc;
            end else begin
                cur_r <= '{write: 1'b1, last: 1'b1, addr: o_hist_ptr, data: hist_word_r};
            end
        end
    end

    // request held until grant, dropped with the last access
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_bus_request_out_n <= PIN_OFF;
            o_bus_owned_ack_n   <= PIN_OFF;
            o_burst_n           <= PIN_OFF;
        end else begin
            if (st_r == ST_IDLE && want && !blocked) o_bus_request_out_n <= 1'b0;
            else if (st_r == ST_DONE && cur_r.last) o_bus_request_out_n <= PIN_OFF;
            if (st_r == ST_WAIT && !pin_s.grant_n) o_bus_owned_ack_n <= 1'b0;
            else if (st_r == ST_DONE && cur_r.last) o_bus_owned_ack_n <= PIN_OFF;
            if (st_r == ST_DONE && !cur_r.last) o_burst_n <= 1'b0;
            else if (st_r == ST_DONE) o_burst_n <= PIN_OFF;
        end
    end

    // grant chain passes through only while nothing is requested
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_grant_chain_out_n <= PIN_OFF;
        end else begin
            o_grant_chain_out_n <= pin_s.grant_n || (st_r != ST_IDLE) || want;
        end
    end

    // bus drive: address gated, data only for writes or register reads
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_bus_drive_indicator_n <= PIN_OFF;
            o_addr_oe_n             <= OE_OFF;
            o_data_oe_n             <= OE_OFF;
            o_addr                  <= '0;
            o_data                  <= '0;
        end else begin
            // indicator covers the setup and strobe cycles of own accesses; register reads drive data without it
            o_bus_drive_indicator_n <= !(st_r == ST_SETUP || st_r == ST_STRB);
            o_addr_oe_n <= !((st_r == ST_SETUP || st_r == ST_STRB) && !pin_s.aen_n);
            o_addr      <= cur_r.addr;
            if (st_r == ST_SETUP || st_r == ST_STRB) begin
                o_data_oe_n <= !cur_r.write;
                o_data      <= cur_r.data;
            end else begin
                o_data_oe_n <= !(host_rd && o_bus_owned_ack_n);
                o_data      <= i_reg_rdata;
            end
        end
    end

    // memory strobes: own access, else host pass-through in pdp mode
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_memory_read_out_n   <= PIN_OFF;
            o_memory_store_out_n  <= PIN_OFF;
            o_memory_select_out_n <= PIN_OFF;
        end else if (st_r == ST_SETUP || st_r == ST_STRB) begin
            o_memory_select_out_n <= 1'b0;
            o_memory_read_out_n   <= cur_r.write;  // opens early: ram settles before capture
            o_memory_store_out_n  <= !(st_r == ST_STRB && cur_r.write);
        end else if (i_pdp_mode && o_bus_owned_ack_n && st_r != ST_OWN) begin
            o_memory_select_out_n <= pin_s.msel_n;
            o_memory_read_out_n   <= pin_s.rd_n;
            o_memory_store_out_n  <= pin_s.wr_n;
        end else begin
            o_memory_select_out_n <= PIN_OFF;
            o_memory_read_out_n   <= PIN_OFF;
            o_memory_store_out_n  <= PIN_OFF;
        end
    end

    // read data capture and completion pulse back to the source
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_acc_done  <= 1'b0;
            o_acc_rdata <= '0;
        end else begin
            o_acc_done <= (st_r == ST_STRB) && !src_hist_r;
            if (st_r == ST_STRB && !cur_r.write) o_acc_rdata <= i_data;
        end
    end

    // history list: a new event wins over the clear of the old one
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hist_pend_r <= 1'b0;
            hist_word_r <= '0;
            o_hist_ptr  <= HIST_BASE;
        end else begin
            if (i_evt_valid) begin
                hist_pend_r <= 1'b1;
                hist_word_r <= i_evt_word;
            end else if (st_r == ST_STRB && src_hist_r) begin
                hist_pend_r <= 1'b0;
            end
            if (st_r == ST_STRB && src_hist_r) o_hist_ptr <= o_hist_ptr + ADDR_ONE;
        end
    end

    // register strobes: one per active edge of rd or wr, blocked while owning
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_prev_r   <= 1'b0;
            wr_prev_r   <= 1'b0;
            o_reg_rd    <= 1'b0;
            o_reg_wr    <= 1'b0;
            o_reg_idx   <= '0;
            o_reg_wdata <= '0;
        end else begin
            rd_prev_r <= !pin_s.rd_n;
            wr_prev_r <= !pin_s.wr_n;
            o_reg_rd  <= !pin_s.cs_n && !pin_s.rd_n && !rd_prev_r && o_bus_owned_ack_n;
            o_reg_wr  <= !pin_s.cs_n && !pin_s.wr_n && !wr_prev_r && o_bus_owned_ack_n;
            o_reg_idx <= pin_s.idx;
            o_reg_wdata <= data_s;
        end
    end

    // legalization bus floats in reset; legality from pin or descriptor
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_lgl_oe_n  <= OE_OFF;
            o_lgl_bus   <= '0;
            o_cmd_legal <= 1'b0;
        end else begin
            o_lgl_oe_n <= !i_bus_lgl_mode;
            if (i_cmd_valid) o_lgl_bus <= i_cmd_word[LGL_W-1:0];
            o_cmd_legal <= i_bus_lgl_mode ? pin_s.legal : i_desc_legal;
        end
    end

    // transmitter-on and channel outputs for the fail-safe timer
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_failsafe_timer_on_ch_a_n <= PIN_OFF;
            o_failsafe_timer_on_ch_b_n <= PIN_OFF;
            o_active_channel_indicator <= 1'b1;
        end else begin
            o_failsafe_timer_on_ch_a_n <= !i_tx_on_a;
            o_failsafe_timer_on_ch_b_n <= !i_tx_on_b;
            o_active_channel_indicator <= i_chan_a_active;
        end
    end

    // checks on the port behaviour
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    a_req_held: assert property ((st_r == ST_WAIT) |=> !o_bus_request_out_n)
        else $error("request dropped before grant");
    a_start_grant: assert property ($fell(o_bus_owned_ack_n) |-> $past(!pin_s.grant_n))
        else $error("ack without grant");
    a_drive_owned: assert property (!o_bus_drive_indicator_n |-> !o_bus_owned_ack_n)
        else $error("driving buses without ack");
    a_addr_gate: assert property (!o_addr_oe_n |-> $past(!pin_s.aen_n))
        else $error("address driven without gate");
    a_chain_idle: assert property (!o_grant_chain_out_n |-> o_bus_request_out_n)
        else $error("grant chained while requesting");
    a_std_strobe: assert property ((!i_pdp_mode && !o_memory_read_out_n) |-> !o_bus_owned_ack_n)
        else $error("memory strobe before grant");
    a_data_float: assert property (!o_data_oe_n |-> (!o_bus_drive_indicator_n ||
                                   $past(host_rd) || !o_memory_store_out_n))
        else $error("data bus driven without cause");
    a_reg_ignore: assert property ((o_reg_rd || o_reg_wr) |-> $past(o_bus_owned_ack_n))
        else $error("register access during own access");
    a_busy_hold: assert property ((st_r == ST_IDLE && blocked) |=> o_bus_request_out_n)
        else $error("dma started while rt busy");
    a_legal_pin: assert property ((i_bus_lgl_mode && $past(i_bus_lgl_mode)) |->
                                  (o_cmd_legal == $past(pin_s.legal)))
        else $error("legal output does not follow pin");

    c_single_xfer: cover property ($fell(o_bus_owned_ack_n) ##[1:20] $rose(o_bus_owned_ack_n));
    c_burst:       cover property ($fell(o_burst_n));
    c_hist_write:  cover property (st_r == ST_STRB && src_hist_r);
    c_reg_write:   cover property (o_reg_wr);
endmodule // bci_port
`default_nettype wire

// [dv/bci_far_model.sv]
// arbiter, shared ram and legality prom as seen from the port's pins
`default_nettype none
module bci_far_model import bci_pkg::*; (
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_arst_n,
    // scenario controls
    input  wire logic              i_slow,
    input  wire logic              i_other_req,
    input  wire logic              i_host_drv,
    input  wire logic [DATA_W-1:0] i_host_wdata,
    // device pins
    input  wire logic              i_req_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_rd_n,
    input  wire logic              i_sel_n,
    input  wire logic [LGL_W-1:0]  i_lgl_bus,
    input  wire logic              i_lgl_oe_n,
    // answers
    output logic                   o_grant_n,
    output logic      [DATA_W-1:0] o_data,
    output logic                   o_legal
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]        wait_r;
    logic [DATA_W-1:0] churn_r;
    // grant after a short or long arbitration, held until the request drops
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wait_r    <= 4'h0;
            o_grant_n <= 1'b1;
        end else if (i_other_req) begin
            o_grant_n <= 1'b0;
        end else if (i_req_n) begin
            wait_r    <= 4'h0;
            o_grant_n <= 1'b1;
        end else if (wait_r == (i_slow ? 4'h9 : 4'h1)) begin
            o_grant_n <= 1'b0;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
    // released bus churns every cycle so stale values never pass as data
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) churn_r <= 16'h1234;
        else churn_r <= churn_r + 16'h9e37;
    end
    // ram answers only while read and select are both low
    assign o_data  = i_host_drv ? i_host_wdata
                   : (!i_rd_n && !i_sel_n) ? (i_addr ^ 16'h5a5a) : churn_r;
    // prom: subaddress field all ones is illegal; floating bus gives junk
    assign o_legal = i_lgl_oe_n ? churn_r[0] : (i_lgl_bus[4:0] != 5'h1f);
endmodule // bci_far_model
`default_nettype wire

// [dv/test_bus_controller_rt_host_dma_interface.sv]
// self-checking bench for the host, dma and legalization port
`default_nettype none
module test_bus_controller_rt_host_dma_interface;
    timeunit 1ns;
    timeprecision 1ps;
    import bci_pkg::*;
    logic clk, rst_n, rtm, busy, pdp, lgl, av, done, ev, memory_read_out, memory_store_out, cs_n, rd_n, wr_n, ms_n;
    logic gnt_n, aen_n, req_n, ack_n, ch_n, drv_n, bst_n, mrd_n, mwr_n, mso_n, aoe_n, doe_n;
    logic cv, dleg, leg, loe_n, cleg, txa, txb, cha, fa_n, fb_n, act, slow, oth, hdrv;
    logic [15:0] ard, evw, hptr, rwd, rdat, haddr, oaddr, din, dout, cmdw, hwd;
    logic [3:0]  ridx;
    logic [10:0] lbus;
    bci_acc_t    acc;
    int          fails, samples_checked;

    bci_port dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_rt_mode(rtm), .i_rt_busy(busy),
        .i_pdp_mode(pdp), .i_bus_lgl_mode(lgl), .i_acc_valid(av), .i_acc(acc),
        .o_acc_done(done), .o_acc_rdata(ard), .i_evt_valid(ev), .i_evt_word(evw),
        .o_hist_ptr(hptr), .o_reg_rd(memory_read_out), .o_reg_wr(memory_store_out), .o_reg_idx(ridx),
        .o_reg_wdata(rwd), .i_reg_rdata(rdat), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_host_memory_select_in_n(ms_n), .i_addr(haddr), .i_bus_grant_in_n(gnt_n),
        .i_address_output_gate_n(aen_n), .o_bus_request_out_n(req_n),
        .o_bus_owned_ack_n(ack_n), .o_grant_chain_out_n(ch_n), .o_bus_drive_indicator_n(drv_n),
        .o_burst_n(bst_n), .o_memory_read_out_n(mrd_n), .o_memory_store_out_n(mwr_n),
        .o_memory_select_out_n(mso_n), .o_addr(oaddr), .o_addr_oe_n(aoe_n), .i_data(din),
        .o_data(dout), .o_data_oe_n(doe_n), .i_cmd_word(cmdw), .i_cmd_valid(cv),
        .i_desc_legal(dleg), .i_command_legal_in(leg), .o_lgl_bus(lbus), .o_lgl_oe_n(loe_n),
        .o_cmd_legal(cleg), .i_tx_on_a(txa), .i_tx_on_b(txb), .i_chan_a_active(cha),
        .o_failsafe_timer_on_ch_a_n(fa_n), .o_failsafe_timer_on_ch_b_n(fb_n),
        .o_active_channel_indicator(act));
    bci_far_model far (.i_sys_clk(clk), .i_arst_n(rst_n), .i_slow(slow), .i_other_req(oth),
        .i_host_drv(hdrv), .i_host_wdata(hwd), .i_req_n(req_n), .i_addr(oaddr),
        .i_rd_n(mrd_n), .i_sel_n(mso_n), .i_lgl_bus(lbus), .i_lgl_oe_n(loe_n),
        .o_grant_n(gnt_n), .o_data(din), .o_legal(leg));

    always #5 clk = ~clk;

    // counts every comparison, reports each mismatch at once
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one core access; the address gate is held shut for gate cycles after ack
    task automatic dma(input logic w, input logic l, input logic [15:0] a, input int gate);
        @(negedge clk);
        acc = '{write: w, last: l, addr: a, data: ~a};
        av = 1'b1;
        aen_n = (gate != 0);
        for (int i = 0; i < 60 && ack_n !== 1'b0; i++) @(negedge clk);
        repeat (gate) begin
            @(negedge clk);
            chk({drv_n, aoe_n, doe_n, mrd_n, mso_n}, 5'h1f);
        end
        aen_n = 1'b0;
        for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge clk);
        chk({done, ack_n}, 2'b10);
        av = 1'b0;
    endtask
    task automatic t_dma_read();
        dma(1'b0, 1'b1, 16'hffff, 4);
        chk(ard, 16'hffff ^ 16'h5a5a);
        repeat (3) @(negedge clk);
        chk({req_n, ack_n, bst_n}, 3'b111);
        $display("test dma_read done");
    endtask
    // burst with slow grant; host register reads are refused while owned
    task automatic t_burst();
        slow = 1'b1;
        dma(1'b1, 1'b0, 16'h0010, 4);
        @(negedge clk);
        chk({bst_n, req_n, ack_n}, 3'b000);
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (6) begin
            @(negedge clk);
            chk(memory_read_out, 1'b0);
        end
        cs_n = 1'b1;
        rd_n = 1'b1;
        dma(1'b0, 1'b1, 16'h0011, 0);
        chk(ard, 16'h0011 ^ 16'h5a5a);
        repeat (3) @(negedge clk);
        chk({bst_n, req_n, ack_n}, 3'b111);
        slow = 1'b0;
        $display("test burst done");
    endtask
    task automatic t_busy();
        rtm = 1'b1;
        busy = 1'b1;
        acc = '{write: 1'b0, last: 1'b1, addr: 16'h0042, data: 16'h0000};
        av = 1'b1;
        repeat (20) begin
            @(negedge clk);
            chk({req_n, done}, 2'b10);
        end
        busy = 1'b0;
        for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge clk);
        chk(done, 1'b1);
        av = 1'b0;
        rtm = 1'b0;
        $display("test busy done");
    endtask
    task automatic t_chain();
        oth = 1'b1;
        repeat (6) @(negedge clk);
        chk(ch_n, 1'b0);
        oth = 1'b0;
        repeat (6) @(negedge clk);
        chk(ch_n, 1'b1);
        $display("test chain done");
    endtask
    // read then write with chip select held low between strobes
    task automatic t_reg();
        haddr = 16'hfff9;
        rdat = 16'hc3a5;
        cs_n = 1'b0;
        rd_n = 1'b0;
        for (int i = 0; i < 8 && memory_read_out !== 1'b1; i++) @(negedge clk);
        chk({memory_read_out, ridx, doe_n, dout}, {1'b1, 4'h9, 1'b0, 16'hc3a5});
        rd_n = 1'b1;
        repeat (4) @(negedge clk);
        haddr = 16'h000c;
        hdrv = 1'b1;
        hwd = 16'h1357;
        wr_n = 1'b0;
        for (int i = 0; i < 8 && memory_store_out !== 1'b1; i++) @(negedge clk);
        chk({memory_store_out, ridx, rwd}, {1'b1, 4'hc, 16'h1357});
        wr_n = 1'b1;
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        hdrv = 1'b0;
        repeat (4) @(negedge clk);
        chk({doe_n, aoe_n}, 2'b11);
        $display("test reg done");
    endtask
    task automatic t_pdp();
        pdp = 1'b1;
        ms_n = 1'b0;
        rd_n = 1'b0;
        repeat (5) @(negedge clk);
        chk({mso_n, mrd_n, mwr_n}, 3'b001);
        rd_n = 1'b1;
        wr_n = 1'b0;
        repeat (5) @(negedge clk);
        chk({mso_n, mrd_n, mwr_n}, 3'b010);
        {ms_n, wr_n} = 2'b11;
        repeat (5) @(negedge clk);
        chk({mso_n, mrd_n, mwr_n}, 3'b111);
        pdp = 1'b0;
        $display("test pdp done");
    endtask
    // legal and illegal subaddress through the prom, then the descriptor method
    task automatic t_legal();
        lgl = 1'b1;
        for (int k = 0; k < 2; k++) begin
            cmdw = k ? 16'hab1f : 16'hfa53;
            cv = 1'b1;
            @(negedge clk);
            cv = 1'b0;
            repeat (5) @(negedge clk);
            chk({loe_n, lbus}, {1'b0, cmdw[10:0]});
            chk(cleg, cmdw[4:0] != 5'h1f);
        end
        lgl = 1'b0;
        dleg = 1'b1;
        repeat (3) @(negedge clk);
        chk({cleg, loe_n}, 2'b11);
        dleg = 1'b0;
        repeat (3) @(negedge clk);
        chk({cleg, loe_n}, 2'b01);
        $display("test legal done");
    endtask
    task automatic t_misc();
        for (int v = 0; v < 8; v++) begin
            {txa, txb, cha} = 3'(v);
            repeat (3) @(negedge clk);
            chk({fa_n, fb_n, act}, {~txa, ~txb, cha});
        end
        ev = 1'b1;
        @(negedge clk);
        ev = 1'b0;
        for (int i = 0; i < 60 && mwr_n !== 1'b0; i++) @(negedge clk);
        chk({mwr_n, aoe_n, doe_n, drv_n}, 4'h0);
        chk({oaddr, dout}, {HIST_BASE_DEF, 16'h7e01});
        repeat (4) @(negedge clk);
        chk(hptr, HIST_BASE_DEF + ADDR_ONE);
        $display("test misc done");
    endtask

    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        fails++;
        end_sim();
    end
    // reset with the legal bus method selected, then the scenarios
    initial begin
        {clk, rst_n, rtm, busy, pdp, av, ev, cv, dleg, txa, txb, slow, oth, hdrv} = '0;
        {lgl, cs_n, rd_n, wr_n, ms_n, cha} = '1;
        {aen_n, acc, evw, rdat, haddr, cmdw, hwd} = '0;
        evw = 16'h7e01;
        fails = 0;
        samples_checked = 0;
        repeat (3) @(negedge clk);
        chk({loe_n, req_n, ack_n, drv_n, aoe_n, doe_n, hptr}, {6'h3f, HIST_BASE_DEF});
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_dma_read();
        t_burst();
        t_busy();
        t_chain();
        t_reg();
        t_pdp();
        t_legal();
        t_misc();
        end_sim();
    end
endmodule // test_bus_controller_rt_host_dma_interface
`default_nettype wire
